// *** flash_spi_pkg.sv ***
// Constants for the serial flash front end.
// Assumes a 20 MHz system clock sampling all serial pins.
// Function
// - Command, address and data bits are taken from serial input on rising clock edges.
// - Output bits change on falling serial clock edges.
// - Select falling enables the device and the master holds it low for a whole command.
// - Clock idling low or high both work with the same edges.
// - Pause starts when the pause input is low while the clock is low, or at the next clock low.
// - Pause ends when the pause input is high while the clock is low, or at the next clock low.
// - While paused the output floats and the clock and input are ignored.
// - Select going high while paused resets the serial logic.
// - A status write is refused when write protect is low and the lock bit is set.
// - Protection level status bits 4:2 (not bit 5) protect the array; the lock bit protects the status register.
// - The array has 4 KB sectors, 32 KB blocks and 64 KB blocks.
// - In auto-increment programming the output shows ready or busy.
// - The lock bit clears at power-up.
// - Bytes move most significant bit first in 8-bit cycles.
package flash_spi_pkg;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 20;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_AUTO_INC = 8'hAD;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] CMD_BLOCK64_ERASE = 8'hD8;
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_LVL_LSB = 2;
  localparam int ST_LVL_MSB = 5;
  localparam int ST_AUTO = 6;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] STATUS_RESET = 8'h1C;
  localparam logic [7:0] STATUS_WR_MASK = 8'hBC;
  localparam int SECTOR_LSB = 12;
  localparam int BLOCK32_LSB = 15;
  localparam int BLOCK64_LSB = 16;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] IDX_OPCODE = 2'h0;
  localparam logic [1:0] IDX_FIRST = 2'h1;
  localparam logic [1:0] IDX_LAST = 2'h3;
endpackage : flash_spi_pkg

// *** flash_spi_front.sv ***
// Serial front end: select, clock edges, pause, status register, protect.
// Assumes serial pins are asynchronous to clk_in and far slower.
`timescale 1ns/1ps
module flash_spi_front
  import flash_spi_pkg::*;
(
  // System
  input wire logic clk_in,
  input wire logic resetn_in,
  // Serial pins
  input wire logic sel_n_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic pause_n_in,
  input wire logic wprot_n_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // Array side
  input wire logic busy_in,
  output logic erase_req_out,
  output logic [flash_spi_pkg::ADDR_BITS-1:0] erase_base_out,
  output logic [7:0] status_out,
  output logic paused_out
);
  import flash_spi_pkg::*;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] sel_s_reg, clk_s_reg, sdi_s_reg, pau_s_reg, wp_s_reg;
  logic clk_d_reg, sel_d_reg;
  logic sel_n, sclk, sdi, pause_n, wprot_n;
  logic rise, fall, sel_fall;
  logic paused_reg;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_cnt_reg;
  logic [7:0] cmd_reg;
  logic [1:0] byte_idx_reg;
  logic [23:0] addr_reg;
  logic [7:0] status_word;
  logic busy_reg, wel_reg, auto_reg, lock_reg;
  logic [ST_LVL_MSB-ST_LVL_LSB:0] level_reg;
  logic [7:0] out_reg;
  logic sdo_reg;
  logic byte_done, active;
  logic wr_allowed;
  // Decoded strobes
  logic opcode_done, status_wr, status_take;
  logic erase_cmd, erase_hit;
  logic [ADDR_BITS-1:0] erase_base_next;
  logic read_load, read_shift;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Two-stage pin synchronisers
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_s_reg <= 2'h3;
      clk_s_reg <= 2'h0;
      sdi_s_reg <= 2'h0;
      pau_s_reg <= 2'h3;
      wp_s_reg <= 2'h3;
    end
    else
    begin
      sel_s_reg <= {sel_s_reg[0], sel_n_in};
      clk_s_reg <= {clk_s_reg[0], sclk_in};
      sdi_s_reg <= {sdi_s_reg[0], sdi_in};
      pau_s_reg <= {pau_s_reg[0], pause_n_in};
      wp_s_reg <= {wp_s_reg[0], wprot_n_in};
    end
  end
  assign sel_n = sel_s_reg[1];
  assign sclk = clk_s_reg[1];
  assign sdi = sdi_s_reg[1];
  assign pause_n = pau_s_reg[1];
  assign wprot_n = wp_s_reg[1];

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
    end
    else
    begin
      clk_d_reg <= sclk;
      sel_d_reg <= sel_n;
    end
  end
  // Edges found the same way whatever the idle level
  assign rise = sclk && !clk_d_reg;
  assign fall = !sclk && clk_d_reg;
  assign sel_fall = sel_d_reg && !sel_n;
  assign active = !sel_n && !paused_reg && !sel_fall;

  // Pause changes only while the clock is low, except that select high clears it
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n) paused_reg <= 1'b0;
    else if (sel_n) paused_reg <= 1'b0;
    else if (!sclk) paused_reg <= !pause_n;
  end
  assign paused_out = paused_reg;

  assign shift_next = {shift_reg[6:0], sdi};
  assign byte_done = active && rise && (bit_cnt_reg == BIT_LAST);
  assign wr_allowed = wprot_n || !lock_reg;

  // Strobes decoded from the byte framing
  assign opcode_done = byte_done && (byte_idx_reg == IDX_OPCODE);
  assign status_wr = byte_done && (byte_idx_reg == IDX_FIRST) &&
    (cmd_reg == CMD_STATUS_WRITE);
  assign status_take = status_wr && wr_allowed && wel_reg;

  // Serial input shifter
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      shift_reg <= 8'h00;
    else if (active && rise)
      shift_reg <= shift_next;
  end

  // Bit count; select high clears it, also from pause
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      bit_cnt_reg <= 3'h0;
    else if (sel_n || sel_fall)
      bit_cnt_reg <= 3'h0;
    else if (active && rise)
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
  end

  // Byte count, held at the last address byte
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      byte_idx_reg <= IDX_OPCODE;
    else if (sel_n || sel_fall)
      byte_idx_reg <= IDX_OPCODE;
    else if (byte_done && byte_idx_reg != IDX_LAST)
      byte_idx_reg <= byte_idx_reg + 2'h1;
  end

  // Opcode of the current command
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      cmd_reg <= 8'h00;
    else if (sel_n || sel_fall)
      cmd_reg <= 8'h00;
    else if (opcode_done)
      cmd_reg <= shift_next;
  end

  // Address bytes after the opcode
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      addr_reg <= 24'h00_0000;
    else if (byte_done && byte_idx_reg != IDX_OPCODE)
      addr_reg <= {addr_reg[15:0], shift_next};
  end

  // Busy flag follows the array
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      busy_reg <= STATUS_RESET[ST_BUSY];
    else
      busy_reg <= busy_in;
  end

  // Write enable; used up by erase and by any status write attempt
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      wel_reg <= STATUS_RESET[ST_WEL];
    else if (status_wr || erase_req_out ||
      (opcode_done && shift_next == CMD_WRITE_DISABLE))
      wel_reg <= 1'b0;
    else if (opcode_done && shift_next == CMD_WRITE_ENABLE)
      wel_reg <= 1'b1;
  end

  // Auto-increment mode flag
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      auto_reg <= STATUS_RESET[ST_AUTO];
    else if (opcode_done && shift_next == CMD_WRITE_DISABLE)
      auto_reg <= 1'b0;
    else if (opcode_done && shift_next == CMD_AUTO_INC && wel_reg)
      auto_reg <= 1'b1;
  end

  // Protection level and lock; a refused write leaves both alone
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_reg <= STATUS_RESET[ST_LVL_MSB:ST_LVL_LSB];
      lock_reg <= STATUS_RESET[ST_LOCK];
    end
    else if (status_take)
    begin
      level_reg <= shift_next[ST_LVL_MSB:ST_LVL_LSB];
      lock_reg <= shift_next[ST_LOCK];
    end
  end

  assign status_word = {lock_reg, auto_reg, level_reg, wel_reg, busy_reg};
  assign status_out = status_word;

  // Erase command seen with its last address byte
  assign erase_cmd = (cmd_reg == CMD_SECTOR_ERASE) ||
    (cmd_reg == CMD_BLOCK32_ERASE) || (cmd_reg == CMD_BLOCK64_ERASE);
  assign erase_hit = byte_done && (byte_idx_reg == IDX_LAST) && erase_cmd;

  always_comb
  begin
    unique case (cmd_reg)
      CMD_SECTOR_ERASE:
        erase_base_next = {addr_reg[11:SECTOR_LSB-8],
          {SECTOR_LSB{1'b0}}};
      CMD_BLOCK32_ERASE:
        erase_base_next = {addr_reg[11:BLOCK32_LSB-8],
          {BLOCK32_LSB{1'b0}}};
      CMD_BLOCK64_ERASE:
        erase_base_next = {addr_reg[11:BLOCK64_LSB-8],
          {BLOCK64_LSB{1'b0}}};
      default:
        erase_base_next = {addr_reg[11:0], shift_next};
    endcase
  end

  // Erase request, only with write enable and the low three level bits (status bits 4:2) clear
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      erase_req_out <= 1'b0;
    else
      erase_req_out <= erase_hit && wel_reg &&
        (level_reg[ST_LVL_MSB-ST_LVL_LSB-1:0] == 3'h0);
  end

  // Base held until the next erase command
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      erase_base_out <= '0;
    else if (erase_hit)
      erase_base_out <= erase_base_next;
  end

  // Status read: load on the first falling edge of a byte
  assign read_load = active && fall && (cmd_reg == CMD_READ_STATUS) &&
    (bit_cnt_reg == 3'h0);
  assign read_shift = active && fall && (cmd_reg == CMD_READ_STATUS) &&
    (bit_cnt_reg != 3'h0);

  // Output copy of the status, rotated one bit per falling edge
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      out_reg <= 8'h00;
    else if (read_load)
      out_reg <= {status_word[6:0], status_word[7]};
    else if (read_shift)
      out_reg <= {out_reg[6:0], out_reg[7]};
  end

  // Output bit, changed only on falling edges
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      sdo_reg <= 1'b0;
    else if (read_load)
      sdo_reg <= status_word[7];
    else if (read_shift)
      sdo_reg <= out_reg[7];
  end

  // Output pin, ready/busy in auto-increment mode
  always_comb
  begin
    sdo_oe_out = !sel_n && !paused_reg &&
      (cmd_reg == CMD_READ_STATUS || auto_reg);
    if (auto_reg && cmd_reg != CMD_READ_STATUS)
      sdo_out = !busy_reg;
    else
      sdo_out = sdo_reg;
  end
endmodule : flash_spi_front

// *** flash_spi_front_properties.sv ***
// Port assertions for the flash front end.
// Bound onto flash_spi_front; sees its ports only.
`timescale 1ns/1ps
module flash_spi_front_properties
  import flash_spi_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sclk_in,
  input wire logic pause_n_in,
  input wire logic sel_n_in,
  input wire logic wprot_n_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic erase_req_out,
  input wire logic [flash_spi_pkg::ADDR_BITS-1:0] erase_base_out,
  input wire logic [7:0] status_out,
  input wire logic paused_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_rst; $rose(resetn_in) |-> status_out == 8'h1C; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_flt; paused_out |-> !sdo_oe_out; endproperty
  a_flt: assert property (p_flt) else $error("drives in pause");
  property p_stay;
    (paused_out && !pause_n_in && !sel_n_in) [*4] |=> paused_out;
  endproperty
  a_stay: assert property (p_stay) else $error("left pause");
  property p_enter;
    (!pause_n_in && !sclk_in && !sel_n_in) [*6] |-> paused_out;
  endproperty
  a_enter: assert property (p_enter) else $error("no pause");
  property p_lock;
    (status_out[7] && !wprot_n_in) [*4] |=> $stable(status_out[7:2]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write");
  property p_sect; erase_req_out |-> erase_base_out[11:0] == 12'h000; endproperty
  a_sect: assert property (p_sect) else $error("base align");
  property p_lvl; erase_req_out |-> status_out[4:2] == 3'h0; endproperty
  a_lvl: assert property (p_lvl) else $error("protected erase");
  property p_edge;
    $changed(sdo_out) && sdo_oe_out && !status_out[6] |-> !$past(sclk_in, 3);
  endproperty
  a_edge: assert property (p_edge) else $error("sdo edge");
endmodule : flash_spi_front_properties
bind flash_spi_front flash_spi_front_properties chk (.clk_in, .resetn_in,
  .sclk_in, .pause_n_in, .sel_n_in, .wprot_n_in, .sdo_out, .sdo_oe_out,
  .erase_req_out, .erase_base_out, .status_out, .paused_out);

// *** spi_host.sv ***
// SPI bus master model for the flash front end bench.
// Steps on falling clk_in edges; one serial bit is 8 cycles.
`timescale 1ns/1ps
module spi_host
(
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic sel_n_out,
  output logic sclk_out,
  output logic sdi_out,
  output logic pause_n_out
);
  logic idle_hi = 1'b0;
  initial {sel_n_out, sclk_out, sdi_out, pause_n_out} = 4'hB;
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wait_n
  task automatic start(input logic hi);
    idle_hi = hi;
    sclk_out = hi;
    wait_n(4);
    sel_n_out = 1'b0;
    wait_n(4);
  endtask : start
  task automatic xfer(input logic [7:0] tx, input int n,
    output logic [7:0] rx);
    for (int i = 7; i >= 8 - n; i--)
    begin
      sclk_out = 1'b0;
      sdi_out = tx[i];
      wait_n(4);
      rx[i] = sdo_in;
      sclk_out = 1'b1;
      wait_n(4);
    end
    sdi_out = ~sdi_out;
  endtask : xfer
  task automatic stop();
    sclk_out = idle_hi;
    wait_n(8);
    sel_n_out = 1'b1;
    wait_n(8);
  endtask : stop
  task automatic pause(input logic lvl);
    pause_n_out = lvl;
    wait_n(8);
  endtask : pause
endmodule : spi_host

// *** serial_flash_spi_front_end_bench.sv ***
// Self-checking bench for the flash front end.
// Assumes spi_host drives the serial pins.
`timescale 1ns/1ps
module serial_flash_spi_front_end_bench;
  import flash_spi_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic wp_n = 1'b0;
  logic busy = 1'b0;
  logic sel_n, sclk, sdi, pause_n, sdo, oe, req, paused;
  logic [ADDR_BITS-1:0] base, seen;
  logic [7:0] status, rx;
  logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hD8};
  logic [19:0] bases [3] = '{20'hF_9000, 20'hF_8000, 20'hF_0000};
  int fails = 0;
  int n_compared = 0;
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) if (req === 1'b1) seen <= base;
  flash_spi_front flash_spi_front_inst (.clk_in, .resetn_in, .sel_n_in(sel_n),
    .sclk_in(sclk), .sdi_in(sdi), .pause_n_in(pause_n), .wprot_n_in(wp_n),
    .sdo_out(sdo), .sdo_oe_out(oe), .busy_in(busy), .erase_req_out(req),
    .erase_base_out(base), .status_out(status), .paused_out(paused));
  spi_host m (.clk_in, .sdo_in(oe ? sdo : 1'bz), .sel_n_out(sel_n),
    .sclk_out(sclk), .sdi_out(sdi), .pause_n_out(pause_n));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic send(input logic [31:0] w, input int nb, input logic hi);
    m.start(hi);
    for (int i = 0; i < nb; i++)
      m.xfer(w[31-8*i -: 8], 8, rx);
    m.stop();
  endtask : send
  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    #1_000_000;
    fails++;
    close_out();
  end
  initial
  begin
    repeat (10) @(negedge clk_in);
    resetn_in = 1'b1;
    m.wait_n(4);
    check(status, 8'h1C);
    m.start(1'b0);
    m.xfer(8'h06, 4, rx);
    m.pause(1'b0);
    m.stop();
    check({paused, status}, 9'h01C);
    m.pause(1'b1);
    m.start(1'b1);
    m.xfer(8'h06, 4, rx);
    m.pause(1'b0);
    check(paused, 1'b0);
    m.xfer(8'hFF, 4, rx);
    check({paused, oe}, 2'h2);
    m.pause(1'b1);
    check(paused, 1'b1);
    m.xfer(8'h60, 4, rx);
    m.stop();
    check(status, 8'h1E);
    send(32'h0180_0000, 2, 1'b0);
    check(status, 8'h80);
    send(32'h0500_0000, 2, 1'b1);
    check(rx, 8'h80);
    send(32'h0600_0000, 1, 1'b0);
    send(32'h013C_0000, 2, 1'b0);
    check(status[7:2], 6'h20);
    wp_n = 1'b1;
    send(32'h0600_0000, 1, 1'b0);
    send(32'h0100_0000, 2, 1'b0);
    check(status, 8'h00);
    foreach (ops[i])
    begin
      seen = '0;
      send(32'h0600_0000, 1, 1'b0);
      send({ops[i], 24'h0F_9234}, 4, 1'b0);
      check(seen, bases[i]);
    end
    send(32'h0600_0000, 1, 1'b0);
    send(32'hAD00_0000, 1, 1'b0);
    check(status, 8'h42);
    m.start(1'b0);
    busy = 1'b1;
    m.wait_n(4);
    check({oe, sdo, status[0]}, 3'h5);
    busy = 1'b0;
    m.wait_n(4);
    check({oe, sdo, status[0]}, 3'h6);
    m.stop();
    send(32'h0400_0000, 1, 1'b0);
    check(status, 8'h00);
    close_out();
  end
endmodule : serial_flash_spi_front_end_bench
